// ### src/mswon_map.vh
// Constants for the switch-on control block: states, timing figures.
// Assumes a 100 MHz system clock; included by bare name.
//
// What this block does
// - From not-powered, a rising main supply starting from below the low threshold starts power-up.
// - If the external reset is low while the supply rises, switch-on waits until it is released.
// - While the supply is being applied the power-on request input is ignored.
// - In power-off, a falling edge on the power-on request held low for the minimum time starts power-on.
// - In power-off, external reset low for more than 705032 cycles (about 7.05 ms) then released starts power-on on the rising edge.
// - In power-off, a due real-time-clock alarm starts power-on as an alternative wake-up.
// - The external reset input idles high through an internal pull-up, also in power-off.
// - The external reset input also acts as a hardware reset during operation.
`ifndef MSWON_MAP_VH
`define MSWON_MAP_VH

// Clock and timing figures
`define MSWON_CLK_MHZ 100
`define MSWON_RESET_LOW_MS 50
`define MSWON_PWRON_LOW_US 50
`define MSWON_CNT_W 24

// One-hot states
`define MSWON_ST_W 5
`define MSWON_ST_UNPOWERED 5'h01
`define MSWON_ST_RAMP 5'h02
`define MSWON_ST_HOLD 5'h04
`define MSWON_ST_ON 5'h08
`define MSWON_ST_OFF 5'h10

`endif

// ### src/mswon_low_timer.v
// Low-time qualifier: synchronises an active-low pin and counts its low time.
// Assumes the pin is asynchronous to sys_clk; no logic reads the first flop.
`timescale 1ns/1ns
module mswon_low_timer #(
  parameter CNT_W = 24,
  parameter [CNT_W-1:0] MIN_CYC = 24'd1
)
(
  input wire sys_clk,
  input wire rstn,
  input wire pin_n,
  output reg level_n,
  output reg qualified,
  output reg fall,
  output reg rise
)
;
  reg sync1;
  reg level_d;
  reg [CNT_W-1:0] low_cnt;

  // ==========================================================
  // Synchroniser and edge detect
  // two-flop sync
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      sync1 <= 1'b1;
      level_n <= 1'b1;
      level_d <= 1'b1;
      fall <= 1'b0;
      rise <= 1'b0;
    end
    else
    begin
      sync1 <= pin_n;
      level_n <= sync1;
      // Edges taken from the second flop and its delayed copy only
      level_d <= level_n;
      fall <= level_d & ~level_n;
      rise <= ~level_d & level_n;
    end
  end

  // ==========================================================
  // Low-time counter; qualified stays high from the minimum until the pin goes high
  // low time count
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      low_cnt <= {CNT_W{1'b0}};
      qualified <= 1'b0;
    end
    else if (level_n)
    begin
      low_cnt <= {CNT_W{1'b0}};
      qualified <= 1'b0;
    end
    else
    begin
      if (low_cnt != MIN_CYC)
        low_cnt <= low_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      qualified <= (low_cnt == MIN_CYC);
    end
  end
endmodule

// ### src/mswon_top.v
// Switch-on control: decides when the internal power-up sequence starts.
// Assumes supply-good and alarm inputs come from the analog supervisor and
// the always-on clock domain; pins arrive asynchronously.
`timescale 1ns/1ns
`include "mswon_map.vh"
module mswon_top #(
  parameter [`MSWON_CNT_W-1:0] RESET_LOW_CYC = `MSWON_RESET_LOW_MS * 1000 * `MSWON_CLK_MHZ * 1000 / 1000,
  parameter [`MSWON_CNT_W-1:0] PWRON_LOW_CYC = `MSWON_PWRON_LOW_US * `MSWON_CLK_MHZ
)
(
  input wire sys_clk,
  input wire rstn,
  input wire supply_low,
  input wire supply_good,
  input wire power_on_request_n,
  input wire ext_reset_n,
  input wire rtc_alarm_due,
  input wire power_off_command,
  output reg power_up_start,
  output reg module_on,
  output reg hw_reset,
  output reg reset_pullup_en
)
;
  reg [`MSWON_ST_W-1:0] state;
  reg [`MSWON_ST_W-1:0] next_state;
  reg sup_low_s1;
  reg sup_low;
  reg sup_good_s1;
  reg sup_good;
  reg alarm_s1;
  reg alarm;
  reg rst_prev;
  reg pwr_prev;
  reg next_start;
  wire rst_level_n;
  wire rst_qual;
  wire pwr_level_n;
  wire pwr_qual;

  // ==========================================================
  // Qualifiers for the two pins
  mswon_low_timer #(.CNT_W(`MSWON_CNT_W), .MIN_CYC(RESET_LOW_CYC)) u_rst
  (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_n(ext_reset_n),
    .level_n(rst_level_n),
    .qualified(rst_qual),
    .fall(),
    .rise()
  );

  mswon_low_timer #(.CNT_W(`MSWON_CNT_W), .MIN_CYC(PWRON_LOW_CYC)) u_pwr
  (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_n(power_on_request_n),
    .level_n(pwr_level_n),
    .qualified(pwr_qual),
    .fall(),
    .rise()
  );

  // ==========================================================
  // Synchronisers for supervisor and alarm levels
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      sup_low_s1 <= 1'b1;
      sup_low <= 1'b1;
      sup_good_s1 <= 1'b0;
      sup_good <= 1'b0;
      alarm_s1 <= 1'b0;
      alarm <= 1'b0;
      rst_prev <= 1'b1;
      pwr_prev <= 1'b0;
    end
    else
    begin
      sup_low_s1 <= supply_low;
      sup_low <= sup_low_s1;
      sup_good_s1 <= supply_good;
      sup_good <= sup_good_s1;
      alarm_s1 <= rtc_alarm_due;
      alarm <= alarm_s1;
      rst_prev <= rst_qual;
      pwr_prev <= pwr_qual;
    end
  end

  // ==========================================================
  // Next-state decode
  always @*
  begin
    next_state = state;
    next_start = 1'b0;
    case (state)
      `MSWON_ST_UNPOWERED:
      begin
        if (sup_low)
          next_state = `MSWON_ST_RAMP;
      end
      `MSWON_ST_RAMP:
      begin
        if (sup_good)
        begin
          if (!rst_level_n)
            next_state = `MSWON_ST_HOLD;
          else
          begin
            next_state = `MSWON_ST_ON;
            next_start = 1'b1;
          end
        end
      end
      `MSWON_ST_HOLD:
      begin
        if (rst_level_n)
        begin
          next_state = `MSWON_ST_ON;
          next_start = 1'b1;
        end
      end
      `MSWON_ST_ON:
      begin
        if (power_off_command)
          next_state = `MSWON_ST_OFF;
      end
      `MSWON_ST_OFF:
      begin
        if (rst_level_n && rst_prev)
        begin
          next_state = `MSWON_ST_ON;
          next_start = 1'b1;
        end
        else if (pwr_qual && !pwr_prev)
        begin
          next_state = `MSWON_ST_ON;
          next_start = 1'b1;
        end
        else if (alarm)
        begin
          next_state = `MSWON_ST_ON;
          next_start = 1'b1;
        end
      end
      default:
        next_state = `MSWON_ST_UNPOWERED;
    endcase
    // Supply collapse returns to not-powered from the hold, on and off states
    if (sup_low && state != `MSWON_ST_UNPOWERED && state != `MSWON_ST_RAMP)
    begin
      next_state = `MSWON_ST_UNPOWERED;
      next_start = 1'b0;
    end
  end

  // ==========================================================
  // State and registered outputs
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state <= `MSWON_ST_UNPOWERED;
      power_up_start <= 1'b0;
      module_on <= 1'b0;
      hw_reset <= 1'b0;
      reset_pullup_en <= 1'b1;
    end
    else
    begin
      state <= next_state;
      power_up_start <= next_start;
      module_on <= (next_state == `MSWON_ST_ON);
      hw_reset <= (state == `MSWON_ST_ON) & ~rst_level_n;
      reset_pullup_en <= 1'b1;
    end
  end
endmodule

// ### tb/mswon_checker.sv
// Checker on the switch-on control ports
// Assumes it is bound to every mswon_top
`timescale 1ns/1ns
module mswon_checker
(
  input wire sys_clk,
  input wire rstn,
  input wire supply_low,
  input wire supply_good,
  input wire power_on_request_n,
  input wire ext_reset_n,
  input wire rtc_alarm_due,
  input wire power_off_command,
  input wire power_up_start,
  input wire module_on,
  input wire hw_reset,
  input wire reset_pullup_en
);
  reg was_on;
  // Marks power-off mode: on once since supply came up
  always @(posedge sys_clk)
  begin
    if (!rstn || supply_low)
      was_on <= 1'b0;
    else if (module_on)
      was_on <= 1'b1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_pullup_kept: assert property (reset_pullup_en)
    else $error("pull-up off");
  a_start_single: assert property (power_up_start |=> !power_up_start)
    else $error("long start");
  a_start_on: assert property (power_up_start |-> ##[0:1] module_on)
    else $error("no on");
  a_on_quiet: assert property (module_on && $past(module_on) |-> !power_up_start)
    else $error("start when on");
  a_alarm_wake: assert property (was_on && !module_on && rtc_alarm_due |-> ##[1:8] module_on)
    else $error("no wake");
  a_hw_reset_pin: assert property ((module_on && !ext_reset_n) [*6] |-> hw_reset)
    else $error("no hw reset");
  a_off_cmd: assert property (power_off_command && module_on |-> ##[1:3] !module_on)
    else $error("still on");
  a_collapse_off: assert property (supply_low [*6] |-> !module_on)
    else $error("on without supply");
endmodule
bind mswon_top mswon_checker i_chk (.*);

// ### tb/mswon_host.sv
// Host model: drives request and reset pins low when pulled, high otherwise
// Assumes the bench says when each pin is pulled low
`timescale 1ns/1ns
module mswon_host
(
  input wire req_pull,
  input wire rst_pull,
  output wire power_on_request_n,
  output wire ext_reset_n
);
  assign power_on_request_n = req_pull ? 1'b0 : 1'b1;
  assign ext_reset_n = rst_pull ? 1'b0 : 1'b1;
endmodule

// ### tb/test_mswon_top.sv
// Bench for switch-on control: supply, pin and alarm wake-ups
// Assumes short low-time counts for a quick run
`timescale 1ns/1ns
module test_mswon_top;
  reg sys_clk, rstn, supply_low, supply_good, rtc_alarm_due, power_off_command, req_pull, rst_pull, seen;
  wire power_on_request_n, ext_reset_n, power_up_start, module_on, hw_reset, reset_pullup_en;
  integer n_fail, n_checks, seed, i;
  reg [31:0] r;
  mswon_host i_host (.*);
  mswon_top #(.RESET_LOW_CYC(24'h14), .PWRON_LOW_CYC(24'ha)) i_dut (.*);
  initial
  begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task tick;
  begin
    @(posedge sys_clk);
    #1;
  end
  endtask
  task chk(input logic got, input logic exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: %b not %b", $time, got, exp);
    end
  end
  endtask
  // Holds one wake source for n cycles, looking for a start then and for 12 cycles after
  task pulse(input integer w, input integer n, input logic e);
  begin
    seen = 0;
    req_pull = (w == 0) || (w == 3);
    rst_pull = (w == 1);
    rtc_alarm_due = (w == 2);
    for (i = 0; i < n + 12; i = i + 1)
    begin
      if (i == n)
      begin
        req_pull = 0;
        rst_pull = 0;
        rtc_alarm_due = 0;
      end
      tick;
      seen = seen | power_up_start;
    end
    chk(seen, e);
  end
  endtask
  task turn_off;
  begin
    power_off_command = 1;
    tick;
    power_off_command = 0;
    repeat (5) tick;
    chk(module_on, 0);
  end
  endtask
  task results;
  begin
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  initial
  begin
    #200000;
    n_fail = n_fail + 1;
    results;
  end
  initial
  begin
    n_fail = 0;
    n_checks = 0;
    seed = 32'h3c6c;
    rstn = 0;
    supply_low = 1;
    supply_good = 0;
    rtc_alarm_due = 0;
    power_off_command = 0;
    req_pull = 0;
    rst_pull = 0;
    repeat (10) tick;
    rstn = 1;
    r = $random(seed);
    supply_low = 0;
    tick;
    supply_good = 1;
    pulse(3, 8, 1);
    turn_off;
    pulse(0, 1 + r[2:1], 0);
    pulse(0, 15, 1);
    turn_off;
    pulse(1, 5, 0);
    pulse(1, 25, 1);
    turn_off;
    pulse(2, 8, 1);
    rst_pull = 1;
    repeat (6) tick;
    chk(hw_reset, 1);
    rst_pull = 0;
    repeat (6) tick;
    chk(hw_reset, 0);
    chk(reset_pullup_en, 1);
    supply_good = 0;
    supply_low = 1;
    repeat (8) tick;
    chk(module_on, 0);
    rst_pull = 1;
    supply_low = 0;
    tick;
    supply_good = 1;
    repeat (12) tick;
    chk(module_on, 0);
    pulse(1, 1, 1);
    results;
  end
endmodule
